// ===== ifp_defines.vh
`ifndef IFP_DEFINES_VH
`define IFP_DEFINES_VH

// Widths
`define IFP_PC_W 21
`define IFP_DA_W 12
`define IFP_SP_W 5
// Phases of one instruction cycle
`define IFP_PHASES 4
`define IFP_PH_RESET 4'h1
// Reset values and stack limits
`define IFP_PC_RESET 21'h000000
`define IFP_SP_RESET 5'h00
`define IFP_SP_FULL 5'h1f
`define IFP_STACK_DEPTH 31
// Program counter step in bytes
`define IFP_PC_STEP 21'h000002
// Opcode patterns
`define IFP_OP_GOTO 8'hef
`define IFP_OP_CALL 7'h76
`define IFP_OP_LOAD_PTR 10'h3b8
`define IFP_OP_MOVE_FF 4'hc
`define IFP_OP_SECOND 4'hf
`define IFP_OP_BRA 5'h1a
`define IFP_OP_RCALL 5'h1b
`define IFP_OP_RET_LIT 8'h0c
`define IFP_OP_RETURN 15'h0009
`define IFP_OP_MOVE_LIT 8'h0e
`define IFP_OP_ADD_WF 6'h09
`define IFP_OP_TEST_SKIP 7'h33
`define IFP_OP_TABLE_RD 14'h0002
// Table read pointer modes
`define IFP_TBL_NONE 2'h0
`define IFP_TBL_POSTINC 2'h1
`define IFP_TBL_POSTDEC 2'h2
`define IFP_TBL_PREINC 2'h3
// Data memory map
`define IFP_PC_LOW_ADDR 8'hf9
`define IFP_ACCESS_SPLIT 8'h60
`define IFP_ACCESS_HIGH 4'hf
`define IFP_BANK_DEFAULT 4'h0
`define IFP_TABLE_BYTE_POINTER_L_ADDR 12'hff6
`define IFP_TABLE_BYTE_POINTER_H_ADDR 12'hff7
`define IFP_TABLE_BYTE_POINTER_U_ADDR 12'hff8

`endif

// ===== ifp_stack_ram.v
`timescale 1ns/100ps
`default_nettype none
module ifp_stack_ram #(
  parameter DATA_W = 21,
  parameter ADDR_W = 5,
  parameter DEPTH = 31
) (
  input wire clk,
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [DATA_W-1:0] wr_data,
  input wire [ADDR_W-1:0] rd_addr,
  output reg [DATA_W-1:0] rd_data
);
  // Entry zero exists only as the empty-stack value
  reg [DATA_W-1:0] mem [0:DEPTH];

  // Write port and registered read port
  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ===== ifp_core.v
// Behaviour
// [RULE_01] Input clock is divided by four into four non-overlapping phases.
// [RULE_02] Program counter advances each first phase; fetched word captured in fourth phase. Code does neither in the cycle a table read borrows.
// [RULE_03] One instruction cycle spans exactly four phases, first through fourth.
// [RULE_04] Fetch of next instruction overlaps execute of current one.
// [RULE_05] Program counter changes cost two cycles; the prefetched word is discarded.
// [RULE_06] Execute captures fetched word in first phase, works through phases two to four.
// [RULE_07] Operand read from data memory in second phase, destination write in fourth.
// [RULE_08] Program memory is byte addressed; instruction words start at even addresses.
// [RULE_09] Program counter steps by two and its low bit always reads zero.
// [RULE_10] Absolute call and jump load their word address into counter bits 20 to 1.
// [RULE_11] Relative branch offsets count single-word instructions, not bytes.
// [RULE_12] Four two-word instructions; second word has 1111 on top, 12 literal bits.
// [RULE_13] A 1111 word supplies data after its first word, otherwise acts as no-op.
// [RULE_14] Adding accumulator to low counter byte advances the counter that many bytes.
// [RULE_15] Return with literal returns and places its 8-bit literal in the accumulator.
// [RULE_16] Table reads use a byte pointer and a data latch, one byte each time.
// [RULE_17] Call increments stack pointer first, then writes return address at new entry.
`include "ifp_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module ifp_core #(
  parameter PC_W = `IFP_PC_W,
  parameter DA_W = `IFP_DA_W,
  parameter SP_W = `IFP_SP_W,
  parameter STACK_DEPTH = `IFP_STACK_DEPTH
) (
  input wire clk,
  input wire resetn,
  output reg [PC_W-1:0] pm_addr,
  output reg pm_rd_en,
  input wire [15:0] pm_rdata,
  output reg [DA_W-1:0] dm_addr,
  output reg dm_rd_en,
  output reg dm_wr_en,
  output reg [7:0] dm_wdata,
  input wire [7:0] dm_rdata,
  output reg first_phase,
  output reg second_phase,
  output reg third_phase,
  output reg fourth_phase,
  output reg [PC_W-1:0] program_counter,
  output reg [7:0] working_accumulator,
  output reg [PC_W-1:0] table_byte_pointer,
  output reg [7:0] table_data_latch,
  output reg [SP_W-1:0] return_stack_pointer,
  output reg [3*DA_W-1:0] indirect_pointers
);
  reg [15:0] fetch_word;
  reg fetch_ok;
  reg [15:0] instruction_holding_register;
  reg exec_ok;
  reg second_in_seq;
  reg pair_pending;
  reg pair_is_ptr;
  reg [5:0] pair_hi;
  reg [7:0] operand;
  reg table_busy;
  reg [1:0] table_mode;
  reg stack_wr;
  reg [PC_W-1:0] stack_wdata;
  wire [PC_W-1:0] stack_top;

  // Maps an 8-bit file operand to a full data address
  function [DA_W-1:0] data_addr;
    input [15:0] w;
    begin
      if (w[8])
        data_addr = {`IFP_BANK_DEFAULT, w[7:0]};
      else if (w[7:0] < `IFP_ACCESS_SPLIT)
        data_addr = {4'h0, w[7:0]};
      else
        data_addr = {`IFP_ACCESS_HIGH, w[7:0]};
    end
  endfunction

  // Source address of a word that reads data memory
  function [DA_W-1:0] operand_addr;
    input [15:0] w;
    begin
      if (w[15:12] == `IFP_OP_MOVE_FF)
        operand_addr = w[11:0];
      else
        operand_addr = data_addr(w);
    end
  endfunction

  // True for words that read an operand
  function op_reads;
    input [15:0] w;
    begin
      op_reads = (w[15:12] == `IFP_OP_MOVE_FF) || (w[15:10] == `IFP_OP_ADD_WF) ||
                 (w[15:9] == `IFP_OP_TEST_SKIP);
    end
  endfunction

  // Relative target: base of next word plus signed word count
  function [PC_W-1:0] rel_target;
    input [PC_W-1:0] pc;
    input [10:0] off;
    begin
      rel_target = pc - `IFP_PC_STEP + {{9{off[10]}}, off, 1'b0};
    end
  endfunction

  // Instruction decode of the executing word
  wire [15:0] ir = instruction_holding_register;
  wire is_goto = exec_ok && (ir[15:8] == `IFP_OP_GOTO);
  wire is_call = exec_ok && (ir[15:9] == `IFP_OP_CALL);
  wire is_ptr1 = exec_ok && (ir[15:6] == `IFP_OP_LOAD_PTR);
  wire is_move1 = exec_ok && (ir[15:12] == `IFP_OP_MOVE_FF);
  wire is_second = exec_ok && second_in_seq && (ir[15:12] == `IFP_OP_SECOND);
  wire is_bra = exec_ok && (ir[15:11] == `IFP_OP_BRA);
  wire is_rcall = exec_ok && (ir[15:11] == `IFP_OP_RCALL);
  wire is_return_with_literal = exec_ok && (ir[15:8] == `IFP_OP_RET_LIT);
  wire is_return = exec_ok && (ir[15:1] == `IFP_OP_RETURN);
  wire is_movlw = exec_ok && (ir[15:8] == `IFP_OP_MOVE_LIT);
  wire is_add_accumulator_to_file = exec_ok && (ir[15:10] == `IFP_OP_ADD_WF);
  wire is_tstfsz = exec_ok && (ir[15:9] == `IFP_OP_TEST_SKIP);
  wire is_tblrd = exec_ok && (ir[15:2] == `IFP_OP_TABLE_RD);
  wire pcl_add = is_add_accumulator_to_file && ir[9] && !ir[8] && (ir[7:0] == `IFP_PC_LOW_ADDR);
  wire skip_taken = is_tstfsz && (operand == 8'h00);
  wire pc_change = is_goto || is_call || is_bra || is_rcall || is_return_with_literal || is_return || pcl_add;
  wire flush = pc_change || skip_taken;
  wire [7:0] add_sum = working_accumulator + operand;

  // New program counter for a flow change, taken in the fourth phase
  reg [PC_W-1:0] next_pc_target;
  always @*
  begin
    next_pc_target = program_counter;
    if (is_goto || is_call)
      next_pc_target = {pm_rdata[11:0], ir[7:0], 1'b0}; // [RULE_10] [RULE_12]
    else if (is_bra || is_rcall)
      next_pc_target = rel_target(program_counter, ir[10:0]); // [RULE_11]
    else if (is_return_with_literal || is_return)
      next_pc_target = stack_top;
    else if (pcl_add)
      next_pc_target = program_counter - `IFP_PC_STEP + {13'h0000, working_accumulator}; // [RULE_14]
  end

  // Rotating phase ring, one phase per input clock
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      {fourth_phase, third_phase, second_phase, first_phase} <= `IFP_PH_RESET;
    end
    else
    begin
      first_phase <= fourth_phase; // [RULE_01] [RULE_03]
      second_phase <= first_phase;
      third_phase <= second_phase;
      fourth_phase <= third_phase;
    end
  end

  // Fetch stage and execute capture
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      program_counter <= `IFP_PC_RESET;
      pm_addr <= `IFP_PC_RESET;
      pm_rd_en <= 1'b0;
      fetch_word <= 16'h0000;
      fetch_ok <= 1'b0;
      instruction_holding_register <= 16'h0000;
      exec_ok <= 1'b0;
      second_in_seq <= 1'b0;
    end
    else
    begin
      if (first_phase)
      begin
        pm_rd_en <= 1'b1;
        second_in_seq <= 1'b0;
        if (table_busy)
        begin
          pm_addr <= {table_byte_pointer[PC_W-1:1], 1'b0}; // [RULE_16]
          exec_ok <= 1'b0;
        end
        else
        begin
          pm_addr <= program_counter; // [RULE_08]
          program_counter <= program_counter + `IFP_PC_STEP; // [RULE_02] [RULE_09]
          instruction_holding_register <= fetch_word; // [RULE_04] [RULE_06]
          exec_ok <= fetch_ok;
          second_in_seq <= pair_pending && fetch_ok; // [RULE_13]
        end
      end
      if (fourth_phase)
      begin
        pm_rd_en <= 1'b0;
        if (!table_busy)
        begin
          fetch_word <= pm_rdata; // [RULE_02]
          fetch_ok <= !flush; // [RULE_05]
        end
        if (pc_change)
        begin
          program_counter <= {next_pc_target[PC_W-1:1], 1'b0}; // [RULE_05] [RULE_09]
        end
      end
    end
  end

  // Data memory strobes: read in second phase, write in fourth
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      dm_addr <= {DA_W{1'b0}};
      dm_rd_en <= 1'b0;
      dm_wr_en <= 1'b0;
      dm_wdata <= 8'h00;
      operand <= 8'h00;
    end
    else
    begin
      if (first_phase && !table_busy && fetch_ok && op_reads(fetch_word))
      begin
        dm_addr <= operand_addr(fetch_word); // [RULE_07]
        dm_rd_en <= 1'b1;
      end
      if (second_phase)
      begin
        dm_rd_en <= 1'b0;
        if (dm_rd_en)
          operand <= dm_rdata; // [RULE_07]
      end
      if (third_phase)
      begin
        if (is_add_accumulator_to_file && ir[9] && !pcl_add)
        begin
          dm_addr <= data_addr(ir);
          dm_wdata <= add_sum;
          dm_wr_en <= 1'b1; // [RULE_07]
        end
        else if (is_second && !pair_is_ptr)
        begin
          dm_addr <= ir[11:0]; // [RULE_13]
          dm_wdata <= operand;
          dm_wr_en <= 1'b1;
        end
      end
      if (fourth_phase)
      begin
        dm_wr_en <= 1'b0;
      end
    end
  end

  // Accumulator and two-word pairing state
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      working_accumulator <= 8'h00;
      pair_pending <= 1'b0;
      pair_is_ptr <= 1'b0;
      pair_hi <= 6'h00;
      indirect_pointers <= {3*DA_W{1'b0}};
    end
    else
    begin
      if (first_phase && !table_busy)
      begin
        pair_pending <= 1'b0;
      end
      if (fourth_phase)
      begin
        if (is_return_with_literal)
          working_accumulator <= ir[7:0]; // [RULE_15]
        else if (is_movlw)
          working_accumulator <= ir[7:0];
        else if (is_add_accumulator_to_file && !ir[9])
          working_accumulator <= add_sum;
        if (is_move1 || is_ptr1)
        begin
          pair_pending <= 1'b1; // [RULE_12]
          pair_is_ptr <= is_ptr1;
          pair_hi <= ir[5:0];
        end
        if (is_second && pair_is_ptr)
        begin
          case (pair_hi[5:4])
            2'h0: indirect_pointers[DA_W-1:0] <= {pair_hi[3:0], ir[7:0]}; // [RULE_13]
            2'h1: indirect_pointers[2*DA_W-1:DA_W] <= {pair_hi[3:0], ir[7:0]};
            2'h2: indirect_pointers[3*DA_W-1:2*DA_W] <= {pair_hi[3:0], ir[7:0]};
            default: indirect_pointers <= indirect_pointers;
          endcase
        end
      end
    end
  end

  // Table read: borrows the next fetch slot, one byte per access
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      table_busy <= 1'b0;
      table_mode <= `IFP_TBL_NONE;
      table_byte_pointer <= {PC_W{1'b0}};
      table_data_latch <= 8'h00;
    end
    else if (fourth_phase)
    begin
      if (table_busy)
      begin
        table_busy <= 1'b0;
        table_data_latch <= table_byte_pointer[0] ? pm_rdata[15:8] : pm_rdata[7:0]; // [RULE_16]
        if (table_mode == `IFP_TBL_POSTINC)
          table_byte_pointer <= table_byte_pointer + 21'h000001;
        else if (table_mode == `IFP_TBL_POSTDEC)
          table_byte_pointer <= table_byte_pointer - 21'h000001;
      end
      else if (is_tblrd)
      begin
        table_busy <= 1'b1;
        table_mode <= ir[1:0];
        if (ir[1:0] == `IFP_TBL_PREINC)
          table_byte_pointer <= table_byte_pointer + 21'h000001;
      end
      else if (dm_wr_en)
      begin
        case (dm_addr)
          `IFP_TABLE_BYTE_POINTER_L_ADDR: table_byte_pointer[7:0] <= dm_wdata;
          `IFP_TABLE_BYTE_POINTER_H_ADDR: table_byte_pointer[15:8] <= dm_wdata;
          `IFP_TABLE_BYTE_POINTER_U_ADDR: table_byte_pointer[20:16] <= dm_wdata[4:0];
          default: table_byte_pointer <= table_byte_pointer;
        endcase
      end
    end
  end

  // Return stack: pointer up in second phase, entry written in third
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      return_stack_pointer <= `IFP_SP_RESET;
      stack_wr <= 1'b0;
      stack_wdata <= {PC_W{1'b0}};
    end
    else
    begin
      stack_wr <= 1'b0;
      if (second_phase && (is_call || is_rcall) && (return_stack_pointer != `IFP_SP_FULL))
      begin
        return_stack_pointer <= return_stack_pointer + 5'h01; // [RULE_17]
      end
      if (second_phase && (is_call || is_rcall))
      begin
        stack_wr <= 1'b1; // [RULE_17]
        stack_wdata <= is_call ? program_counter : program_counter - `IFP_PC_STEP;
      end
      if (fourth_phase && (is_return_with_literal || is_return) && (return_stack_pointer != `IFP_SP_RESET))
      begin
        return_stack_pointer <= return_stack_pointer - 5'h01; // [RULE_15]
      end
    end
  end

  // Return address store
  ifp_stack_ram #(
    .DATA_W(PC_W),
    .ADDR_W(SP_W),
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk(clk),
    .wr_en(stack_wr),
    .wr_addr(return_stack_pointer),
    .wr_data(stack_wdata),
    .rd_addr(return_stack_pointer),
    .rd_data(stack_top)
  );
endmodule
`default_nettype wire

// ===== ifp_core_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ifp_core_chk #(
  parameter PC_W = 21,
  parameter SP_W = 5
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [PC_W-1:0] pm_addr,
  input wire logic pm_rd_en,
  input wire logic dm_rd_en,
  input wire logic dm_wr_en,
  input wire logic first_phase,
  input wire logic second_phase,
  input wire logic third_phase,
  input wire logic fourth_phase,
  input wire logic [PC_W-1:0] program_counter,
  input wire logic [SP_W-1:0] return_stack_pointer
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Phase ring after the first phase
  sequence s_ring;
    second_phase ##1 third_phase ##1 fourth_phase ##1 first_phase;
  endsequence
  property p_onehot; $onehot({first_phase, second_phase, third_phase, fourth_phase}); endproperty
  property p_ring; first_phase |=> s_ring; endproperty
  property p_fetch_addr; $changed(pm_addr) |-> second_phase; endproperty
  property p_fetch_en; pm_rd_en == !first_phase; endproperty
  property p_align; program_counter[0] == 1'b0 && pm_addr[0] == 1'b0; endproperty
  property p_dm_rd; dm_rd_en |-> second_phase; endproperty
  property p_dm_wr; dm_wr_en |-> fourth_phase; endproperty
  property p_stack; $changed(return_stack_pointer) |-> third_phase || first_phase; endproperty
  a_onehot: assert property (p_onehot) else $error("phase outputs not one-hot");
  a_ring: assert property (p_ring) else $error("phase ring out of order");
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address moved off first phase");
  a_fetch_en: assert property (p_fetch_en) else $error("fetch enable wrong for phase");
  a_align: assert property (p_align) else $error("odd program address");
  a_dm_rd: assert property (p_dm_rd) else $error("operand read outside second phase");
  a_dm_wr: assert property (p_dm_wr) else $error("data write outside fourth phase");
  a_stack: assert property (p_stack) else $error("stack pointer moved at wrong phase");
endmodule
bind ifp_core ifp_core_chk #(.PC_W(PC_W), .SP_W(SP_W)) i_chk (.clk(clk), .resetn(resetn),
  .pm_addr(pm_addr), .pm_rd_en(pm_rd_en), .dm_rd_en(dm_rd_en), .dm_wr_en(dm_wr_en),
  .first_phase(first_phase), .second_phase(second_phase), .third_phase(third_phase),
  .fourth_phase(fourth_phase), .program_counter(program_counter),
  .return_stack_pointer(return_stack_pointer));
`default_nettype wire

// ===== ifp_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ifp_mem_model (
  input wire logic clk,
  input wire logic [20:0] pm_addr,
  input wire logic pm_rd_en,
  output logic [15:0] pm_rdata,
  input wire logic [11:0] dm_addr,
  input wire logic dm_rd_en,
  input wire logic dm_wr_en,
  input wire logic [7:0] dm_wdata,
  output logic [7:0] dm_rdata
);
  logic [15:0] prog [0:63];
  logic [7:0] data [0:4095];
  logic [15:0] last_pm;
  logic [7:0] last_dm;
  // Unselected memory shows the inverse of its last answer
  assign pm_rdata = pm_rd_en ? prog[pm_addr[6:1]] : ~last_pm;
  assign dm_rdata = dm_rd_en ? data[dm_addr] : ~last_dm;
  // Word lookup by byte address with the low bit dropped
  always @(posedge clk)
  begin
    if (pm_rd_en)
      last_pm <= prog[pm_addr[6:1]];
    if (dm_rd_en)
      last_dm <= data[dm_addr];
    if (dm_wr_en)
      data[dm_addr] <= dm_wdata;
  end
  // Memory contents at start
  initial
  begin
    last_pm = 16'h0000;
    last_dm = 8'h00;
    for (int i = 0; i < 4096; i++)
      data[i] = 8'h00;
    for (int i = 0; i < 64; i++)
      prog[i] = 16'h0000;
  end
endmodule
`default_nettype wire

// ===== instruction_fetch_pipeline_tb.sv
`timescale 1ns/100ps
`default_nettype none
module instruction_fetch_pipeline_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [20:0] pm_addr;
  logic pm_rd_en;
  logic [15:0] pm_rdata;
  logic [11:0] dm_addr;
  logic dm_rd_en;
  logic dm_wr_en;
  logic [7:0] dm_wdata;
  logic [7:0] dm_rdata;
  logic first_phase, second_phase, third_phase, fourth_phase;
  logic [20:0] program_counter;
  logic [7:0] working_accumulator;
  logic [20:0] table_byte_pointer;
  logic [7:0] table_data_latch;
  logic [4:0] return_stack_pointer;
  logic [35:0] indirect_pointers;
  logic [19:0] wr_log [$];
  logic saw_goto = 1'b0;
  logic saw_pcl = 1'b0;
  int err_total = 0;
  int tests_run = 0;
  always #25 clk = ~clk;
  ifp_core i_dut (.clk(clk), .resetn(resetn), .pm_addr(pm_addr), .pm_rd_en(pm_rd_en),
    .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_rd_en(dm_rd_en), .dm_wr_en(dm_wr_en),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .first_phase(first_phase),
    .second_phase(second_phase), .third_phase(third_phase), .fourth_phase(fourth_phase),
    .program_counter(program_counter), .working_accumulator(working_accumulator),
    .table_byte_pointer(table_byte_pointer), .table_data_latch(table_data_latch),
    .return_stack_pointer(return_stack_pointer), .indirect_pointers(indirect_pointers));
  ifp_mem_model i_mem (.clk(clk), .pm_addr(pm_addr), .pm_rd_en(pm_rd_en), .pm_rdata(pm_rdata),
    .dm_addr(dm_addr), .dm_rd_en(dm_rd_en), .dm_wr_en(dm_wr_en), .dm_wdata(dm_wdata),
    .dm_rdata(dm_rdata));
  // Log data writes and fetch targets
  always @(posedge clk)
  begin
    if (resetn && dm_wr_en)
      wr_log.push_back({dm_addr, dm_wdata});
    if (resetn && second_phase && pm_addr === 21'h000020)
      saw_goto <= 1'b1;
    if (resetn && second_phase && pm_addr === 21'h000016)
      saw_pcl <= 1'b1;
  end
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_of_test;
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wait_until_sp(input logic [4:0] v);
    int n;
    n = 0;
    while (return_stack_pointer !== v && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk("stack wait", n < 200, 1);
  endtask
  task t_reset;
    chk("reset phase", {first_phase, second_phase, third_phase, fourth_phase}, 4'h8);
    chk("reset pc", program_counter, 21'h000000);
    chk("reset sp", return_stack_pointer, 5'h00);
    chk("reset strobes", {pm_rd_en, dm_rd_en, dm_wr_en}, 3'h0);
    $display("reset test done");
  endtask
  task t_call;
    wait_until_sp(5'h01);
    chk("acc in call", working_accumulator, 8'h04);
    wait_until_sp(5'h00);
    chk("computed goto fetch", saw_pcl, 1'b1);
    chk("literal return", working_accumulator, 8'h33);
    $display("call test done");
  endtask
  task t_flow;
    int n;
    n = 0;
    while (wr_log.size() < 3 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk("write count", wr_log.size(), 3);
    chk("add write", wr_log[0], 20'h02043);
    chk("move write", wr_log[1], 20'h0415a);
    chk("pointer write", wr_log[2], 20'hff65a);
    chk("goto target", saw_goto, 1'b1);
    chk("flushed load", working_accumulator, 8'h33);
    $display("flow test done");
  endtask
  task t_table;
    repeat (40) @(negedge clk);
    chk("table pointer", table_byte_pointer, 21'h00005b);
    chk("table latch", table_data_latch, 8'hcd);
    chk("pointer one", indirect_pointers[23:12], 12'h123);
    chk("other pointers", {indirect_pointers[35:24], indirect_pointers[11:0]}, 24'h000000);
    chk("loop pc", program_counter[20:4], 17'h00003);
    $display("table test done");
  endtask
  // Program: call into a computed table, add, goto, skip a move, pointer load, table read, loop
  initial
  begin
    // Load memories once the model has cleared them
    repeat (10) @(negedge clk);
    i_mem.prog[0] = 16'h0e04;
    i_mem.prog[1] = 16'hec08;
    i_mem.prog[2] = 16'hf000;
    i_mem.prog[3] = 16'h2720;
    i_mem.prog[4] = 16'hef10;
    i_mem.prog[5] = 16'hf000;
    i_mem.prog[8] = 16'h26f9;
    i_mem.prog[9] = 16'h0c11;
    i_mem.prog[10] = 16'h0c22;
    i_mem.prog[11] = 16'h0c33;
    i_mem.prog[12] = 16'h0eee;
    i_mem.prog[16] = 16'h6721;
    i_mem.prog[17] = 16'hc030;
    i_mem.prog[18] = 16'hf040;
    i_mem.prog[19] = 16'hc030;
    i_mem.prog[20] = 16'hf041;
    i_mem.prog[21] = 16'hc030;
    i_mem.prog[22] = 16'hfff6;
    i_mem.prog[23] = 16'hee11;
    i_mem.prog[24] = 16'hf023;
    i_mem.prog[25] = 16'h0009;
    i_mem.prog[26] = 16'hd7ff;
    i_mem.prog[45] = 16'habcd;
    i_mem.data[12'h020] = 8'h10;
    i_mem.data[12'h030] = 8'h5a;
    t_reset();
    resetn = 1'b1;
    t_call();
    t_flow();
    t_table();
    end_of_test();
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #100000;
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
